// ---- smbcfg_pkg.sv ----
// Purpose: Shared constants, types and register map of the SMBus config port
// Assumes: Core clock 50 MHz, link sampling clock period 6 ns
// Notes:   Offsets are byte indexes on the SMBus register space
package smbcfg_pkg;

	// Slave address: byte 0xB0 plus two per address-select step
	localparam logic [6:0] BASE_ADDR7 = 7'h58;

	// Register indexes
	localparam int unsigned    REG_COUNT        = 8;
	localparam logic [7:0]     REG_STRAP        = 8'h00;
	localparam logic [7:0]     REG_CHAN_PD      = 8'h01;
	localparam logic [7:0]     REG_PIN_OVR      = 8'h02;
	localparam logic [7:0]     REG_BUS_CTRL     = 8'h06;
	localparam logic [7:0]     REG_SOFT_RST     = 8'h07;

	// Field positions
	localparam int unsigned STRAP_SEL_LSB     = 3;
	localparam int unsigned LOAD_DONE_BIT     = 2;
	localparam int unsigned OVR_PIN_BIT       = 0;
	localparam int unsigned REG_EN_BIT        = 3;
	localparam int unsigned SOFT_RST_REGS_BIT = 6;
	localparam int unsigned SOFT_RST_MSTR_BIT = 5;

	// Read-only overlay of register 0 and self-clearing bits of register 7
	localparam logic [7:0] STRAP_RO_MASK  = 8'h7C;
	localparam logic [7:0] SOFT_RST_SC    = 8'h60;

	// Values after reset, one per register index
	localparam logic [7:0] REG_RESET [0:REG_COUNT-1] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h01
	};

	// Bus timing, figures in ns, link clock period in ps
	localparam int unsigned LINK_PERIOD_PS = 6000;
	localparam int unsigned T_BUF_NS       = 4700;
	localparam int unsigned T_HIGH_MAX_NS  = 50000;
	// Least time rounds up, longest time rounds down
	localparam int unsigned TBUF_CYCLES  = (T_BUF_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
	localparam int unsigned THIGH_CYCLES = (T_HIGH_MAX_NS * 1000) / LINK_PERIOD_PS;
	localparam int unsigned IDLE_CNT_W   = 16;

	// Register request from link domain to core domain
	typedef struct packed {
		logic       wr;
		logic [7:0] index;
		logic [7:0] data;
	} smbcfg_req_t;

	// Link state machine, one-hot
	typedef enum logic [8:0] {
		ST_IDLE      = 9'h001,
		ST_ADDR      = 9'h002,
		ST_ADDR_ACK  = 9'h004,
		ST_INDEX     = 9'h008,
		ST_INDEX_ACK = 9'h010,
		ST_WDATA     = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA     = 9'h080,
		ST_RDATA_ACK = 9'h100
	} smbcfg_state_t;

endpackage

// ---- smbcfg_sync.sv ----
// Purpose: Two flip-flop synchroniser for static or slow levels
// Assumes: Bits of a vector are independent levels
// Notes:   Only the second stage may be read by logic
`timescale 1ns/1ns
module smbcfg_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         i_clk,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// No reset: the chain flushes within two edges
	always_ff @(posedge i_clk) begin
		meta_r <= i_d;
		sync_r <= meta_r;
	end

	assign o_q = sync_r;
endmodule

// ---- smbcfg_line_watch.sv ----
// Purpose: Start, stop, clock edge and idle detection on sampled SCL/SDA
// Assumes: Inputs already synchronised to i_clk
// Notes:   Idle counts are in i_clk cycles
`timescale 1ns/1ns
module smbcfg_line_watch
	import smbcfg_pkg::*;
#(
	parameter int unsigned BUF_CYC  = TBUF_CYCLES,
	parameter int unsigned HIGH_CYC = THIGH_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_start,
	output logic      o_stop,
	output logic      o_scl_rise,
	output logic      o_scl_fall,
	output logic      o_idle
);
	logic                  scl_d_r;
	logic                  sda_d_r;
	logic                  after_stop_r;
	logic                  idle_r;
	logic [IDLE_CNT_W-1:0] cnt_r;

	// Previous line levels for edge detection
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= i_scl;
			sda_d_r <= i_sda;
		end
	end

	// SDA edges only count while SCL stays high on both samples
	assign o_start    = scl_d_r & i_scl & sda_d_r & ~i_sda;  // [RULE_02]
	assign o_stop     = scl_d_r & i_scl & ~sda_d_r & i_sda;  // [RULE_03]
	assign o_scl_rise = ~scl_d_r & i_scl;
	assign o_scl_fall = scl_d_r & ~i_scl;

	// Both-high time counter, saturating
	always_ff @(posedge i_clk) begin
		if (i_rst || !(i_scl && i_sda)) begin
			cnt_r <= '0;
		end else if (cnt_r != '1) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// Idle after bus-free time past a stop, or after max high time
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			after_stop_r <= 1'b0;
			idle_r       <= 1'b1;
		end else if (o_start) begin
			after_stop_r <= 1'b0;
			idle_r       <= 1'b0;
		end else begin
			if (o_stop) begin
				after_stop_r <= 1'b1;
			end
			if ((after_stop_r && cnt_r >= IDLE_CNT_W'(BUF_CYC))
			    || cnt_r >= IDLE_CNT_W'(HIGH_CYC)) begin
				idle_r <= 1'b1;  // [RULE_04]
			end
		end
	end

	assign o_idle = idle_r;
endmodule

// ---- smbcfg_top.sv ----
// Purpose: SMBus slave port with configuration registers 0x00..0x07
// Assumes: i_link_clk samples SCL/SDA, runs well above bus rate
// Notes:   SDA is open drain; o_sda_oe high pulls the line low

`timescale 1ns/1ns

// Functional notes
// (RULE_01) SDA holds steady while SCL high
// (RULE_02) SDA fall during SCL high is start
// (RULE_03) SDA rise during SCL high is stop
// (RULE_04) Long both-high time makes bus idle
// (RULE_05) Slave port works only with strap high
// (RULE_06) Select zero answers address byte B0
// (RULE_07) Sixteen addresses, B0 to CE, step two
// (RULE_08) Host write: start, address, index, data, stop
// (RULE_09) Acknowledge address, index and data bytes low
// (RULE_10) Host read: index write, restart, read address
// (RULE_11) Shift selected register out after read address
// (RULE_12) Host ends read with nack and stop
// (RULE_13) Register 0 bits 6:3 show live select
// (RULE_14) Register 0 bit 2 shows load done
// (RULE_15) Register 1 powers down channels, beats pin; code ORs the pin in unless register 2 bit 0 blocks it
// (RULE_16) Register 2 bit 0 blocks power-down pin
// (RULE_17) Register 6 bit 3 enables register control
// (RULE_18) Register 7 bit 6 restores all defaults
// (RULE_19) Register 7 bit 5 resets EEPROM master
// (RULE_20) Software writes reserved fields their values
// (RULE_21) Read-write, read-only types, documented reset values
// (RULE_22) Unmatched address: no acknowledge, ignore message
// (RULE_23) Keep index for following repeated-start read
module smbcfg_top
	import smbcfg_pkg::*;
#(
	parameter int unsigned HIGH_MAX_CYCLES = THIGH_CYCLES,
	parameter int unsigned CHANNELS        = 8
) (
	input  wire logic                i_clk,
	input  wire logic                i_rst,
	input  wire logic                i_link_clk,
	input  wire logic                i_scl,
	input  wire logic                i_sda,
	output logic                     o_sda,
	output logic                     o_sda_oe,
	input  wire logic                i_slave_mode_strap,
	input  wire logic [3:0]          i_addr_sel,
	input  wire logic                i_power_down_pin,
	input  wire logic                i_eeprom_load_done,
	output logic [CHANNELS-1:0]      o_per_channel_shutdown_bits,
	output logic                     o_register_control_en,
	output logic                     o_eeprom_master_reset,
	output logic                     o_bus_idle
);

	// Link domain signals
	logic                lrst;
	logic                scl_l;
	logic                sda_l;
	logic                strap_l;
	logic [3:0]          sel_l;
	logic                start_l;
	logic                stop_l;
	logic                rise_l;
	logic                fall_l;
	logic                idle_l;
	logic                ack_sync_l;
	smbcfg_state_t       state_r;
	logic [3:0]          bit_cnt_r;
	logic [7:0]          shift_r;
	logic [7:0]          index_r;
	logic [7:0]          tx_r;
	logic [7:0]          rd_byte_r;
	logic                sda_oe_r;
	logic                sda_out_r;
	smbcfg_req_t         req_r;
	logic                req_tgl_r;
	logic                ack_seen_r;
	logic                rx_state;
	logic                byte_fall;
	logic                addr_hit;
	logic                pending;

	// Core domain signals
	logic                req_sync_c;
	logic                req_seen_r;
	logic                new_req;
	logic                rd_pend_r;
	logic [7:0]          rd_data_r;
	logic                ack_tgl_r;
	logic [3:0]          sel_c;
	logic                pd_pin_c;
	logic                load_done_c;
	logic [7:0]          regs_r [0:REG_COUNT-1];
	logic [CHANNELS-1:0] shutdown_r;
	logic                reg_ctrl_en_r;
	logic                mstr_rst_r;

	// Register read with the read-only overlay of register 0
	function automatic logic [7:0] reg_read(
		input logic [7:0] idx,
		input logic [7:0] stored,
		input logic [3:0] sel,
		input logic       done
	);
		logic [7:0] v;
		v = 8'h00;
		if (idx < 8'(REG_COUNT)) begin
			v = stored;
		end
		if (idx == REG_STRAP) begin
			v = stored & ~STRAP_RO_MASK;
			v[STRAP_SEL_LSB +: 4] = sel;   // [RULE_13]
			v[LOAD_DONE_BIT]      = done;  // [RULE_14]
		end
		return v;
	endfunction

	// Reset into the link domain, then pins and the answer toggle
	smbcfg_sync #(.W(1)) u_lrst_sync (
		.i_clk (i_link_clk),
		.i_d   (i_rst),
		.o_q   (lrst)
	);

	smbcfg_sync #(.W(8)) u_link_sync (
		.i_clk (i_link_clk),
		.i_d   ({i_scl, i_sda, i_slave_mode_strap, i_addr_sel, ack_tgl_r}),
		.o_q   ({scl_l, sda_l, strap_l, sel_l, ack_sync_l})
	);

	smbcfg_line_watch #(
		.BUF_CYC  (TBUF_CYCLES),
		.HIGH_CYC (HIGH_MAX_CYCLES)
	) u_watch (
		.i_clk      (i_link_clk),
		.i_rst      (lrst),
		.i_scl      (scl_l),
		.i_sda      (sda_l),
		.o_start    (start_l),
		.o_stop     (stop_l),
		.o_scl_rise (rise_l),
		.o_scl_fall (fall_l),
		.o_idle     (idle_l)
	);

	// Byte decode shared by the state, drive and request logic
	assign rx_state  = (state_r == ST_ADDR) || (state_r == ST_INDEX)
	                   || (state_r == ST_WDATA);
	assign byte_fall = fall_l && rx_state && (bit_cnt_r == 4'h8);
	// Address byte B0 + 2 * select; strap low never matches
	assign addr_hit  = strap_l && (shift_r[7:1] == (BASE_ADDR7 + {3'h0, sel_l}));  // [RULE_05] [RULE_06] [RULE_07]
	assign pending   = req_tgl_r != ack_sync_l;

	// Protocol state, bit counter and receive shifter
	always_ff @(posedge i_link_clk) begin
		if (lrst) begin
			state_r   <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r   <= 8'h00;
		end else if (start_l) begin
			// Repeated start lands here too
			state_r   <= ST_ADDR;
			bit_cnt_r <= 4'h0;
		end else if (stop_l || idle_l) begin
			state_r   <= ST_IDLE;
			bit_cnt_r <= 4'h0;
		end else begin
			case (state_r)
				ST_ADDR, ST_INDEX, ST_WDATA: begin
					if (rise_l && bit_cnt_r != 4'h8) begin
						shift_r   <= {shift_r[6:0], sda_l};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (byte_fall) begin
						bit_cnt_r <= 4'h0;
						if (state_r == ST_ADDR) begin
							state_r <= addr_hit ? ST_ADDR_ACK : ST_IDLE;  // [RULE_22]
						end else if (state_r == ST_INDEX) begin
							state_r <= ST_INDEX_ACK;
						end else begin
							state_r <= ST_WDATA_ACK;
						end
					end
				end
				ST_ADDR_ACK: begin
					// Direction bit still in shift_r[0]
					if (fall_l) begin
						state_r <= shift_r[0] ? ST_RDATA : ST_INDEX;
					end
				end
				ST_INDEX_ACK, ST_WDATA_ACK: begin
					if (fall_l) begin
						state_r <= ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (fall_l) begin
						if (bit_cnt_r == 4'h7) begin
							state_r   <= ST_RDATA_ACK;
							bit_cnt_r <= 4'h0;
						end else begin
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
				end
				ST_RDATA_ACK: begin
					// Master answer sampled on the high phase
					if (rise_l) begin
						shift_r <= {shift_r[6:0], sda_l};
					end else if (fall_l) begin
						state_r <= shift_r[0] ? ST_IDLE : ST_RDATA;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// SDA drive changes only just after SCL falls
	always_ff @(posedge i_link_clk) begin
		if (lrst) begin
			sda_oe_r <= 1'b0;
			tx_r     <= 8'h00;
		end else if (start_l || stop_l || idle_l) begin
			sda_oe_r <= 1'b0;
		end else if (fall_l) begin  // [RULE_01]
			case (state_r)
				ST_ADDR, ST_INDEX, ST_WDATA: begin
					if (byte_fall) begin
						sda_oe_r <= (state_r != ST_ADDR) || addr_hit;  // [RULE_09] [RULE_22]
					end
				end
				ST_ADDR_ACK: begin
					tx_r     <= rd_byte_r;
					sda_oe_r <= shift_r[0] && !rd_byte_r[7];  // [RULE_11]
				end
				ST_RDATA: begin
					tx_r     <= {tx_r[6:0], 1'b0};
					sda_oe_r <= (bit_cnt_r != 4'h7) && !tx_r[6];  // [RULE_11]
				end
				ST_RDATA_ACK: begin
					// Acked byte is sent again; nack releases
					tx_r     <= rd_byte_r;
					sda_oe_r <= !shift_r[0] && !rd_byte_r[7];
				end
				default: begin
					sda_oe_r <= 1'b0;
				end
			endcase
		end
	end

	// Open drain: the data flop only ever carries low
	always_ff @(posedge i_link_clk) begin
		sda_out_r <= 1'b0;
	end

	// Index kept across repeated start
	always_ff @(posedge i_link_clk) begin
		if (lrst) begin
			index_r <= 8'h00;
		end else if (byte_fall && state_r == ST_INDEX) begin
			index_r <= shift_r;  // [RULE_23]
		end
	end

	// Requests: index refresh, data write, and refresh on read address
	// A request while one is pending is dropped; bus bit times dwarf it
	always_ff @(posedge i_link_clk) begin
		if (lrst) begin
			req_r     <= '0;
			req_tgl_r <= 1'b0;
		end else if (byte_fall && !pending) begin
			if (state_r == ST_INDEX) begin
				req_r     <= '{wr: 1'b0, index: shift_r, data: 8'h00};
				req_tgl_r <= ~req_tgl_r;
			end else if (state_r == ST_WDATA) begin
				req_r     <= '{wr: 1'b1, index: index_r, data: shift_r};
				req_tgl_r <= ~req_tgl_r;
			end else if (addr_hit && shift_r[0]) begin
				req_r     <= '{wr: 1'b0, index: index_r, data: 8'h00};  // [RULE_23]
				req_tgl_r <= ~req_tgl_r;
			end
		end
	end

	// Answer byte taken once the core toggle arrives
	always_ff @(posedge i_link_clk) begin
		if (lrst) begin
			ack_seen_r <= 1'b0;
			rd_byte_r  <= 8'h00;
		end else begin
			ack_seen_r <= ack_sync_l;
			if (ack_sync_l != ack_seen_r) begin
				rd_byte_r <= rd_data_r;
			end
		end
	end

	assign o_sda    = sda_out_r;
	assign o_sda_oe = sda_oe_r;

	// Core side: request toggle and pins into i_clk
	smbcfg_sync #(.W(7)) u_core_sync (
		.i_clk (i_clk),
		.i_d   ({req_tgl_r, i_addr_sel, i_power_down_pin, i_eeprom_load_done}),
		.o_q   ({req_sync_c, sel_c, pd_pin_c, load_done_c})
	);

	assign new_req = req_sync_c != req_seen_r;

	// Register file; a write lands a cycle before its read-back
	always_ff @(posedge i_clk) begin
		if (i_rst || (new_req && req_r.wr && req_r.index == REG_SOFT_RST
		              && req_r.data[SOFT_RST_REGS_BIT])) begin
			for (int k = 0; k < REG_COUNT; k++) begin
				regs_r[k] <= REG_RESET[k];  // [RULE_18] [RULE_21]
			end
		end else if (new_req && req_r.wr && req_r.index < 8'(REG_COUNT)) begin
			if (req_r.index == REG_SOFT_RST) begin
				regs_r[req_r.index[2:0]] <= req_r.data & ~SOFT_RST_SC;  // [RULE_19]
			end else begin
				regs_r[req_r.index[2:0]] <= req_r.data;  // [RULE_21]
			end
		end
	end

	// Handshake: answer one cycle after the write settles
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			req_seen_r <= 1'b0;
			rd_pend_r  <= 1'b0;
			rd_data_r  <= 8'h00;
			ack_tgl_r  <= 1'b0;
		end else begin
			req_seen_r <= req_sync_c;
			rd_pend_r  <= new_req;
			if (rd_pend_r) begin
				rd_data_r <= reg_read(req_r.index, regs_r[req_r.index[2:0]],
				                      sel_c, load_done_c);
				ack_tgl_r <= ~ack_tgl_r;
			end
		end
	end

	// Channel power down: register bits ORed with the pin unless pin blocked
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			shutdown_r    <= '0;
			reg_ctrl_en_r <= 1'b0;
			mstr_rst_r    <= 1'b0;
		end else begin
			shutdown_r    <= regs_r[REG_CHAN_PD[2:0]][CHANNELS-1:0]
			                 | {CHANNELS{pd_pin_c
			                 & !regs_r[REG_PIN_OVR[2:0]][OVR_PIN_BIT]}};  // [RULE_15] [RULE_16]
			reg_ctrl_en_r <= regs_r[REG_BUS_CTRL[2:0]][REG_EN_BIT];  // [RULE_17]
			mstr_rst_r    <= new_req && req_r.wr && req_r.index == REG_SOFT_RST
			                 && req_r.data[SOFT_RST_MSTR_BIT];  // [RULE_19]
		end
	end

	assign o_per_channel_shutdown_bits = shutdown_r;
	assign o_register_control_en       = reg_ctrl_en_r;
	assign o_eeprom_master_reset       = mstr_rst_r;
	assign o_bus_idle                  = idle_l;
endmodule

// ---- smbcfg_chk.sv ----
// Purpose: Port-level assertions on the SMBus config port
// Assumes: Bound to smbcfg_top; link clock far faster than SCL
// Notes:   Idle figures are link cycles with both lines high at the pins
`timescale 1ns/1ns
module smbcfg_chk #(
	parameter int unsigned HIGH_MAX_CYCLES = 200
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_link_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe,
	input wire logic i_slave_mode_strap,
	input wire logic o_register_control_en,
	input wire logic o_eeprom_master_reset,
	input wire logic o_bus_idle
);
	// Both-high run length; reset keeps it free of unknowns
	logic [31:0] hi_cnt_r;
	always_ff @(posedge i_link_clk) begin
		if (i_rst || !(i_scl && i_sda)) begin
			hi_cnt_r <= 32'h00000000;
		end else begin
			hi_cnt_r <= hi_cnt_r + 32'h00000001;
		end
	end

	property p_sda_stable;
		@(posedge i_link_clk) disable iff (i_rst) $changed(o_sda_oe) |-> !i_scl;
	endproperty
	a_sda_stable: assert property (p_sda_stable)
		else $error("SDA drive moved while SCL high");
	property p_start_busy;
		@(posedge i_link_clk) disable iff (i_rst)
		o_bus_idle && i_scl && $fell(i_sda) |-> ##[1:8] !o_bus_idle;
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("start did not leave idle");
	property p_idle_min;
		@(posedge i_link_clk) disable iff (i_rst) $rose(o_bus_idle) |-> hi_cnt_r >= HIGH_MAX_CYCLES - 2;
	endproperty
	a_idle_min: assert property (p_idle_min)
		else $error("idle flagged too early");
	property p_idle_max;
		@(posedge i_link_clk) disable iff (i_rst) hi_cnt_r == HIGH_MAX_CYCLES + 8 |-> o_bus_idle;
	endproperty
	a_idle_max: assert property (p_idle_max)
		else $error("idle not flagged after long high");
	property p_strap_off;
		@(posedge i_link_clk) disable iff (i_rst) (!i_slave_mode_strap)[*8] |-> !o_sda_oe;
	endproperty
	a_strap_off: assert property (p_strap_off)
		else $error("SDA driven with slave mode off");
	property p_ack_low;
		@(posedge i_link_clk) disable iff (i_rst)
		$rose(o_sda_oe) |-> !i_scl && !$past(i_scl, 3) && !o_sda;
	endproperty
	a_ack_low: assert property (p_ack_low)
		else $error("drive began outside SCL low");
	property p_mreset_pulse;
		@(posedge i_clk) disable iff (i_rst) o_eeprom_master_reset |=> !o_eeprom_master_reset;
	endproperty
	a_mreset_pulse: assert property (p_mreset_pulse)
		else $error("master reset longer than one cycle");
	property p_reset_vals;
		@(posedge i_clk) disable iff (i_rst)
		$fell(i_rst) |-> !o_register_control_en && !o_eeprom_master_reset;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("outputs not at defaults after reset");
endmodule

bind smbcfg_top smbcfg_chk #(.HIGH_MAX_CYCLES(HIGH_MAX_CYCLES)) u_chk (
	.i_clk(i_clk), .i_rst(i_rst), .i_link_clk(i_link_clk), .i_scl(i_scl), .i_sda(i_sda),
	.o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_slave_mode_strap(i_slave_mode_strap),
	.o_register_control_en(o_register_control_en),
	.o_eeprom_master_reset(o_eeprom_master_reset), .o_bus_idle(o_bus_idle)
);

// ---- smbcfg_host.sv ----
// Purpose: Behavioural SMBus host master driving SCL and SDA
// Assumes: SDA has a pull-up; quarter bit is five core cycles
// Notes:   Changes land on core falling edges only
`timescale 1ns/1ns
module smbcfg_host (
	input  wire logic i_clk,
	input  wire logic i_sda_oe,
	output logic      o_scl,
	output logic      o_sda
);
	logic sda_low = 1'b0;
	initial o_scl = 1'b1;
	// Wired-AND with pull-up: released line reads high
	assign o_sda = !(sda_low || i_sda_oe);

	task automatic q();
		repeat (5) @(negedge i_clk);
	endtask
	// Start, or repeated start when SCL is already low
	task automatic start();
		sda_low = 1'b0;
		q();
		o_scl = 1'b1;
		q();
		sda_low = 1'b1;
		q();
		o_scl = 1'b0;
	endtask
	task automatic stop();
		q();
		sda_low = 1'b1;
		q();
		o_scl = 1'b1;
		q();
		sda_low = 1'b0;
		q();
	endtask
	// Data set only in the SCL low half
	task automatic bitx(input logic b, output logic r);
		q();
		sda_low = !b;
		q();
		o_scl = 1'b1;
		q();
		r = o_sda;
		q();
		o_scl = 1'b0;
	endtask
	// MSB first; ninth bit released for ack, or a nack after a read
	task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack);
		logic b_in;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], b_in);
			r[i] = b_in;
		end
		bitx(1'b1, ack);
	endtask
endmodule

// ---- smbus_slave_config_port_test.sv ----
// Purpose: Register-level regression of the SMBus config port
// Assumes: Host model drives the pins; straps set between messages
// Notes:   Idle time shortened through HIGH_MAX_CYCLES
`timescale 1ns/1ns
module smbus_slave_config_port_test;
	import smbcfg_pkg::*;
	localparam int unsigned HIGH_SIM = 200;
	logic       clk = 1'b0;
	logic       link_clk = 1'b0;
	logic       rst = 1'b1;
	logic       scl, sda, sda_oe, ctrl_en, mreset, idle, nk, dsda;
	logic       strap = 1'b1;
	logic       pd_pin = 1'b0;
	logic       done = 1'b1;
	logic [3:0] sel = 4'h0;
	logic [7:0] shut, rv, addr = 8'hB0, mr_cnt = 8'h00;
	logic [2:0] ak;
	int         num_errors = 0, check_count = 0, cyc = 0, tnum = 0;

	always #10 clk = ~clk;
	always #3 link_clk = ~link_clk;

	smbcfg_top #(.HIGH_MAX_CYCLES(HIGH_SIM)) dut (
		.i_clk(clk), .i_rst(rst), .i_link_clk(link_clk), .i_scl(scl), .i_sda(sda),
		.o_sda(dsda), .o_sda_oe(sda_oe), .i_slave_mode_strap(strap), .i_addr_sel(sel),
		.i_power_down_pin(pd_pin), .i_eeprom_load_done(done),
		.o_per_channel_shutdown_bits(shut), .o_register_control_en(ctrl_en),
		.o_eeprom_master_reset(mreset), .o_bus_idle(idle)
	);
	// Open drain: the line goes low only when enabled with a low data bit
	smbcfg_host host (.i_clk(clk), .i_sda_oe(sda_oe && !dsda), .o_scl(scl), .o_sda(sda));

	// Pulses are one cycle wide; counted mid-cycle, clear of the launch edge
	always @(negedge clk) begin
		if (mreset === 1'b1) mr_cnt <= mr_cnt + 8'h01;
		cyc++;
		if (cyc == 80000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tdone();
		tnum++;
		$display("test %0d finished", tnum);
	endtask
	// Single-byte write; the gap after stop lets the core apply it
	task automatic put(input logic [7:0] a8, input logic [7:0] idx, input logic [7:0] d,
		input logic [7:0] exp_ak);
		host.start();
		host.byte_io(a8, rv, ak[2]);
		host.byte_io(idx, rv, ak[1]);
		host.byte_io(d, rv, ak[0]);
		host.stop();
		repeat (20) @(negedge clk);
		chk({5'h00, ak}, exp_ak);
	endtask
	task automatic get(input logic [7:0] idx, input logic [7:0] exp);
		host.start();
		host.byte_io(addr, rv, ak[2]);
		host.byte_io(idx, rv, ak[1]);
		host.start();
		host.byte_io(addr | 8'h01, rv, ak[0]);
		host.byte_io(8'hFF, rv, nk);
		host.stop();
		repeat (20) @(negedge clk);
		chk({5'h00, ak}, 8'h00);
		chk({7'h00, nk}, 8'h01);
		chk(rv, exp);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (20) @(negedge clk);
		chk({7'h00, idle}, 8'h01);
		chk({7'h00, ctrl_en}, 8'h00);
		get(8'h00, 8'h04);
		for (int i = 1; i < 8; i++) get(8'(i), REG_RESET[i]);
		get(8'h08, 8'h00);
		tdone();
		// Every strap value, plus a neighbour address that must be ignored
		for (int s = 0; s < 16; s++) begin
			sel = 4'(s);
			done = sel[0];
			addr = 8'hB0 + {3'h0, sel, 1'b0};
			repeat (10) @(negedge clk);
			get(8'h00, {1'b0, sel, sel[0], 2'b00});
			put(addr ^ 8'h02, 8'h01, 8'hFF, 8'h07);
		end
		get(8'h01, 8'h00);
		sel = 4'h0;
		done = 1'b1;
		addr = 8'hB0;
		repeat (10) @(negedge clk);
		tdone();
		put(addr, 8'h01, 8'hA5, 8'h00);
		chk(shut, 8'hA5);
		pd_pin = 1'b1;
		repeat (5) @(negedge clk);
		chk(shut, 8'hFF);
		put(addr, 8'h02, 8'h01, 8'h00);
		chk(shut, 8'hA5);
		get(8'h02, 8'h01);
		put(addr, 8'h06, 8'h18, 8'h00);
		chk({7'h00, ctrl_en}, 8'h01);
		get(8'h06, 8'h18);
		put(addr, 8'h00, 8'h7C, 8'h00);
		get(8'h00, 8'h04);
		tdone();
		put(addr, 8'h07, 8'h21, 8'h00);
		chk(mr_cnt, 8'h01);
		get(8'h07, 8'h01);
		put(addr, 8'h07, 8'h41, 8'h00);
		chk({7'h00, ctrl_en}, 8'h00);
		chk(shut, 8'hFF);
		get(8'h01, 8'h00);
		get(8'h06, 8'h10);
		get(8'h00, 8'h04);
		tdone();
		strap = 1'b0;
		repeat (10) @(negedge clk);
		put(addr, 8'h01, 8'h3C, 8'h07);
		strap = 1'b1;
		repeat (10) @(negedge clk);
		get(8'h01, 8'h00);
		repeat (100) @(negedge clk);
		chk({7'h00, idle}, 8'h01);
		tdone();
		report_and_stop();
	end
endmodule
